// *** design/afbi_apb_regs.sv ***
/*
  APB slave holding the controller's own registers.
  Assumes APB3 signalling; answers with zero wait states, unmapped reads zero.
*/
`timescale 1ns/10ps
module afbi_apb_regs (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        eng_busy,
  input  wire logic [31:0] status_in,
  input  wire logic [15:0] rdata_in,
  output logic      [2:0]  op_start,
  output logic      [23:0] addr_out,
  output logic      [15:0] wdata_out,
  output logic      [31:0] cfg_out
);
  typedef struct packed {
    logic [31:0] prdata;
    logic [2:0]  op;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [31:0] cfg;
  } afbi_regs_t;

  afbi_regs_t s_q;
  afbi_regs_t s_d;
  logic       wr_en;

  assign wr_en     = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign prdata    = s_q.prdata;
  assign op_start  = s_q.op;
  assign addr_out  = s_q.addr;
  assign wdata_out = s_q.wdata;
  assign cfg_out   = s_q.cfg;

  always_comb
  begin
    s_d    = s_q;
    s_d.op = afbi_pkg::OP_NONE;
    // Start ignored while an operation runs
    if (wr_en && paddr == afbi_pkg::REG_CTRL && !eng_busy)
      s_d.op = pwdata[afbi_pkg::CTRL_OP_LSB +: 3];
    if (wr_en && paddr == afbi_pkg::REG_ADDR)
      s_d.addr = pwdata[23:0];
    if (wr_en && paddr == afbi_pkg::REG_WDATA)
      s_d.wdata = pwdata[15:0];
    if (wr_en && paddr == afbi_pkg::REG_CFG)
      s_d.cfg = pwdata;
    // Read data registered in setup so it is stable in access
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        afbi_pkg::REG_ADDR:   s_d.prdata = {8'h00, s_q.addr};
        afbi_pkg::REG_WDATA:  s_d.prdata = {16'h0000, s_q.wdata};
        afbi_pkg::REG_RDATA:  s_d.prdata = {16'h0000, rdata_in};
        afbi_pkg::REG_STATUS: s_d.prdata = status_in;
        afbi_pkg::REG_CFG:    s_d.prdata = s_q.cfg;
        default:              s_d.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_q       <= '0;
      s_q.cfg   <= afbi_pkg::CFG_RESET;
    end
    else
      s_q <= s_d;
  end
endmodule

// *** design/afbi_host.sv ***
/*
  Host controller for an asynchronous parallel flash: sequences reads, command
  writes, reset pulses and the page length configure pair on the flash pins.
  Assumes pins are synchronous to clk_sys and an external pull-up on busy.
*/
`timescale 1ns/10ps
module afbi_host (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output afbi_pkg::afbi_pins_t         pins,
  input  wire afbi_pkg::afbi_pins_in_t pins_in
);
  typedef enum logic [7:0] {
    ST_IDLE  = 8'b0000_0001,
    ST_RD    = 8'b0000_0010,
    ST_WRLO  = 8'b0000_0100,
    ST_WRHI  = 8'b0000_1000,
    ST_RSTLO = 8'b0001_0000,
    ST_RECOV = 8'b0010_0000,
    ST_GAP   = 8'b0100_0000,
    ST_DONE  = 8'b1000_0000
  } afbi_state_t;

  typedef struct packed {
    afbi_state_t                  st;
    logic [afbi_pkg::CNT_W-1:0]   cnt;
    logic [1:0]                   step;
    logic [15:0]                  rdata;
    logic                         eight;
    logic                         busy_seen;
    afbi_pkg::afbi_pins_t         pins;
  } afbi_host_t;

  afbi_host_t  s_q;
  afbi_host_t  s_d;
  logic [2:0]  op;
  logic [23:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [31:0] cfg;
  logic [31:0] status;
  logic        eng_busy;
  logic [15:0] cmd_data;
  logic [23:0] cmd_addr;

  assign eng_busy = (s_q.st != ST_IDLE);
  assign status   = {29'h0, s_q.eight, s_q.st == ST_IDLE, eng_busy};
  assign pins     = s_q.pins;

  afbi_apb_regs i_afbi_apb_regs (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .eng_busy  (eng_busy),
    .status_in (status),
    .rdata_in  (s_q.rdata),
    .op_start  (op),
    .addr_out  (reg_addr),
    .wdata_out (reg_wdata),
    .cfg_out   (cfg)
  );

  // Configure sequence: command, confirm, then clear status if eight-word
  always_comb
  begin
    cmd_addr = reg_addr;
    cmd_data = reg_wdata;
    if (s_q.step == 2'd0)
    begin
      cmd_data = afbi_pkg::CMD_PAGE_CFG;
      cmd_addr = {8'h00, 2'b00, cfg[afbi_pkg::CFG_EIGHT_BIT], 13'h0000};
    end
    else if (s_q.step == 2'd1)
    begin
      cmd_data = afbi_pkg::CMD_PAGE_CONF;
      cmd_addr = {8'h00, 2'b00, cfg[afbi_pkg::CFG_EIGHT_BIT], 13'h0000};
    end
    else if (s_q.step == 2'd2)
      cmd_data = afbi_pkg::CMD_CLR_STATUS;
  end

  always_comb
  begin
    s_d = s_q;
    if (s_q.cnt != '0)
      s_d.cnt = s_q.cnt - 1'b1;
    s_d.pins.byte_n = cfg[afbi_pkg::CFG_BYTE_BIT];
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.pins.chip_select_0 = 1'b1;
        s_d.pins.oe_n          = 1'b1;
        s_d.pins.we_n          = 1'b1;
        s_d.pins.dq_oe_n       = 1'b1;
        s_d.step               = 2'd3;
        case (op)
          afbi_pkg::OP_READ:
          begin
            s_d.pins.addr          = reg_addr;
            s_d.pins.chip_select_0 = 1'b0;
            s_d.pins.oe_n          = 1'b0;
            s_d.cnt                = afbi_pkg::CNT_W'(afbi_pkg::ACCESS_CYC);
            s_d.st                 = ST_RD;
          end
          afbi_pkg::OP_WRITE:
          begin
            s_d.pins.addr   = reg_addr;
            s_d.pins.dq_out = reg_wdata;
            s_d.st          = ST_GAP;
            s_d.cnt         = '0;
          end
          afbi_pkg::OP_PAGECFG:
          begin
            s_d.step = 2'd0;
            s_d.st   = ST_GAP;
            s_d.cnt  = '0;
          end
          afbi_pkg::OP_RESET:
          begin
            s_d.pins.powerdown_reset_n = 1'b0;
            s_d.cnt = pins_in.busy_indicator ?
                      afbi_pkg::CNT_W'(afbi_pkg::RST_IDLE_CYC) :
                      afbi_pkg::CNT_W'(afbi_pkg::RST_BUSY_CYC);
            s_d.st  = ST_RSTLO;
          end
          default:
            s_d.st = ST_IDLE;
        endcase
      end
      ST_GAP:
      begin
        // read strobe off before write strobe
        s_d.pins.oe_n = 1'b1;
        if (s_q.step != 2'd3)
        begin
          s_d.pins.addr   = cmd_addr;
          s_d.pins.dq_out = cmd_data;
        end
        s_d.pins.chip_select_0 = 1'b0;
        s_d.pins.dq_oe_n       = 1'b0;
        s_d.pins.we_n          = 1'b0;
        s_d.cnt                = afbi_pkg::CNT_W'(afbi_pkg::WR_PULSE_CYC);
        s_d.st                 = ST_WRLO;
      end
      ST_WRLO:
        if (s_q.cnt == '0)
        begin
          s_d.pins.we_n = 1'b1;
          s_d.cnt       = afbi_pkg::CNT_W'(afbi_pkg::WR_HIGH_CYC);
          s_d.st        = ST_WRHI;
        end
      ST_WRHI:
        if (s_q.cnt == '0)
        begin
          s_d.pins.dq_oe_n = 1'b1;
          s_d.st           = ST_DONE;
          if (s_q.step == 2'd0)
          begin
            s_d.step = 2'd1;
            s_d.st   = ST_GAP;
          end
          else if (s_q.step == 2'd1)
          begin
            // host copy tracks the volatile setting
            s_d.eight = cfg[afbi_pkg::CFG_EIGHT_BIT];
            s_d.step  = cfg[afbi_pkg::CFG_EIGHT_BIT] ? 2'd2 : 2'd3;
            s_d.st    = cfg[afbi_pkg::CFG_EIGHT_BIT] ? ST_GAP : ST_DONE;
          end
          else if (s_q.step == 2'd2)
            s_d.step = 2'd3;
        end
      ST_RD:
        if (s_q.cnt == '0)
        begin
          // device drives only while read enabled
          s_d.rdata         = pins_in.dq_in;
          s_d.pins.oe_n     = 1'b1;
          s_d.st            = ST_DONE;
        end
      ST_RSTLO:
        if (s_q.cnt == '0)
        begin
          s_d.pins.powerdown_reset_n = 1'b1;
          s_d.eight                  = 1'b0;
          s_d.busy_seen              = 1'b0;
          s_d.cnt                    = afbi_pkg::CNT_W'(afbi_pkg::RST_RECOV_CYC);
          s_d.st                     = ST_RECOV;
        end
      ST_RECOV:
      begin
        // recovery counted from later of busy or reset rise
        if (!pins_in.busy_indicator)
          s_d.cnt = afbi_pkg::CNT_W'(afbi_pkg::RST_RECOV_CYC);
        else if (s_q.cnt == '0)
          s_d.st = ST_DONE;
      end
      ST_DONE:
      begin
        s_d.pins.chip_select_0 = 1'b1;
        s_d.st                 = ST_IDLE;
      end
      default:
        s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_q                        <= '0;
      s_q.st                     <= ST_IDLE;
      s_q.step                   <= 2'd3;
      s_q.pins.powerdown_reset_n <= 1'b1;
      s_q.pins.chip_select_0     <= 1'b1;
      s_q.pins.oe_n              <= 1'b1;
      s_q.pins.we_n              <= 1'b1;
      s_q.pins.dq_oe_n           <= 1'b1;
    end
    else
      s_q <= s_d;
  end
endmodule

// *** dv/afbi_flash_model.sv ***
/*
  Behavioural flash device on the far side of the pins.
  Assumes pins move just after clk_sys edges; times kept in cycles.
*/
`timescale 1ns/10ps
module afbi_flash_model #(
  parameter logic [15:0] PROG_CMD = 16'h0040,
  // Supply tied high; low only models the lockout
  parameter logic        PROG_SUPPLY_HIGH = 1'b1,
  parameter int          BUSY_CYC = 200
) (
  input  wire logic                    clk_sys,
  input  wire afbi_pkg::afbi_pins_t    pins,
  output afbi_pkg::afbi_pins_in_t      pins_in
);
  logic [15:0] cmd_q   = 16'h0000;
  logic [15:0] wd_q    = 16'h0000;
  logic [15:0] wa_q    = 16'h0000;
  logic [15:0] last_q  = 16'h0000;
  logic [8:0]  busy_q  = 9'h000;
  logic [3:0]  rec_q   = 4'h0;
  logic [1:0]  acc_q   = 2'h0;
  logic        wel_q   = 1'b1;
  logic        stat_q  = 1'b0;
  logic        eight_q = 1'b0;
  logic        en;
  logic        drv;
  logic [15:0] word;
  assign en = pins.chip_select_2 ? !(pins.chip_select_1 && pins.chip_select_0) :
                                   !(pins.chip_select_1 || pins.chip_select_0);
  // any page word; status is one word
  assign word = stat_q ? {8'h00, busy_q == 9'h000, 7'h00} : pins.addr[16:1] ^ 16'hC3A5;
  // data only after access and recovery
  assign drv = en && !pins.oe_n && pins.we_n && pins.powerdown_reset_n && acc_q[1] && rec_q == 4'h0;
  assign pins_in.dq_in[15:8] = drv && pins.byte_n ? word[15:8] : ~last_q[15:8];
  assign pins_in.dq_in[7:0] = !drv ? ~last_q[7:0] : (pins.byte_n || !pins.addr[0] ? word[7:0] : word[15:8]);
  // low while busy, released in reset
  assign pins_in.busy_indicator = busy_q == 9'h000 || !pins.powerdown_reset_n;
  always @(posedge clk_sys)
  begin
    last_q <= pins_in.dq_in;
    wel_q <= pins.we_n;
    acc_q <= en && !pins.oe_n ? {acc_q[0], 1'b1} : 2'b00;
    if (!pins.we_n)
    begin
      wd_q <= pins.dq_out;
      wa_q <= pins.addr[15:0];
    end
    if (busy_q != 9'h000)
      busy_q <= busy_q - 9'h001;
    if (rec_q != 4'h0)
      rec_q <= rec_q - 4'h1;
    if (!pins.powerdown_reset_n)
    begin
      busy_q <= 9'h000;
      rec_q <= 4'(afbi_pkg::RST_RECOV_CYC);
      stat_q <= 1'b0;
      eight_q <= 1'b0;
      cmd_q <= 16'h0000;
    end
    // latch on strobe rise; read wins
    else if (en && !wel_q && pins.we_n && pins.oe_n)
    begin
      cmd_q <= wd_q;
      if (cmd_q == afbi_pkg::CMD_PAGE_CFG && wd_q == afbi_pkg::CMD_PAGE_CONF)
        eight_q <= wa_q[13];
      if (wd_q == PROG_CMD && PROG_SUPPLY_HIGH)
        busy_q <= 9'(BUSY_CYC);
      if (wd_q != afbi_pkg::CMD_CLR_STATUS)
        stat_q <= !(wd_q == afbi_pkg::CMD_READ_ARRAY || wd_q == afbi_pkg::CMD_PAGE_CFG ||
                    cmd_q == afbi_pkg::CMD_PAGE_CFG);
    end
  end
endmodule

// *** dv/afbi_host_asserts.sv ***
/*
  Checker for the flash host pins.
  Assumes a bind to afbi_host; one clock, sync reset.
*/
`timescale 1ns/10ps
module afbi_host_asserts (
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire afbi_pkg::afbi_pins_t    pins,
  input wire afbi_pkg::afbi_pins_in_t pins_in
);
  logic [9:0]  low_q;
  logic        busy_q;
  logic [15:0] cfg_q;
  // Low time of the reset pin, busy seen just before it fell
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      low_q  <= 10'h000;
      busy_q <= 1'b0;
      cfg_q  <= 16'h0000;
    end
    else
    begin
      low_q <= pins.powerdown_reset_n ? 10'h000 : low_q + 10'h001;
      if (pins.powerdown_reset_n)
        busy_q <= !pins_in.busy_indicator;
      if (!pins.we_n && pins.dq_out == afbi_pkg::CMD_PAGE_CFG)
        cfg_q <= pins.addr[15:0];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_cmd(logic [15:0] code);
    $fell(pins.we_n) && pins.dq_out == code;
  endsequence
  property p_no_oe_we;
    pins.oe_n || pins.we_n;
  endproperty
  a_no_oe_we: assert property (p_no_oe_we) else $error("strobes overlap");
  property p_rd_qual;
    !pins.oe_n |-> !pins.chip_select_0 && pins.we_n && pins.powerdown_reset_n && pins.dq_oe_n;
  endproperty
  a_rd_qual: assert property (p_rd_qual) else $error("bad read qualifiers");
  property p_rst_idle;
    $fell(pins.powerdown_reset_n) |-> ##1 !pins.powerdown_reset_n;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("reset pulse short");
  property p_rst_busy;
    $rose(pins.powerdown_reset_n) && busy_q |-> low_q >= afbi_pkg::RST_BUSY_CYC;
  endproperty
  a_rst_busy: assert property (p_rst_busy) else $error("busy reset pulse short");
  property p_recov;
    $rose(pins.powerdown_reset_n) |-> (pins.oe_n && pins.we_n)[*5];
  endproperty
  a_recov: assert property (p_recov) else $error("access before recovery");
  property p_wr_hold;
    !pins.we_n && !$past(pins.we_n) |-> $stable(pins.addr) && $stable(pins.dq_out) && !pins.dq_oe_n;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data moved");
  property p_page_stable;
    !pins.oe_n && !$past(pins.oe_n) |-> $stable(pins.addr) && $stable(pins.chip_select_0);
  endproperty
  a_page_stable: assert property (p_page_stable) else $error("read address moved");
  property p_cfg_pair;
    s_cmd(afbi_pkg::CMD_PAGE_CFG) |-> ##[1:20] s_cmd(afbi_pkg::CMD_PAGE_CONF) ##0 pins.addr[15:0] == cfg_q;
  endproperty
  a_cfg_pair: assert property (p_cfg_pair) else $error("no matching confirm");
  property p_clr_status;
    s_cmd(afbi_pkg::CMD_PAGE_CONF) ##0 pins.addr[13] |-> ##[1:20] s_cmd(afbi_pkg::CMD_CLR_STATUS);
  endproperty
  a_clr_status: assert property (p_clr_status) else $error("no clear status");
endmodule

bind afbi_host afbi_host_asserts i_afbi_host_asserts (.clk_sys(clk_sys), .rst(rst), .pins(pins), .pins_in(pins_in));

// *** dv/afbi_host_tb.sv ***
/*
  Bench for the flash host: APB tasks drive the map, a flash model answers.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/10ps
module afbi_host_tb;
  logic                    clk_sys;
  logic                    rst;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic [31:0]             rd;
  logic [15:0]             w;
  afbi_pkg::afbi_pins_t    pins;
  afbi_pkg::afbi_pins_in_t pins_in;
  int                      err_count;
  int                      samples_checked;

  afbi_host i_afbi_host (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .pins(pins), .pins_in(pins_in));
  afbi_flash_model i_afbi_flash_model (.clk_sys(clk_sys), .pins(pins), .pins_in(pins_in));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] fw(input logic [23:0] x);
    return x[16:1] ^ 16'hC3A5;
  endfunction

  task automatic conclude();
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic hang();
    err_count++;
    $display("[FAIL] %0t wait ran out", $time);
    conclude();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
    if (n >= 50)
      hang();
  endtask

  // Start one operation, poll idle, fetch read data
  task automatic op(input logic [2:0] c, input logic [23:0] ad, input logic [15:0] d);
    int n;
    apb(1'b1, afbi_pkg::REG_ADDR, {8'h00, ad});
    apb(1'b1, afbi_pkg::REG_WDATA, {16'h0000, d});
    apb(1'b1, afbi_pkg::REG_CTRL, {29'h0000_0000, c});
    n = 0;
    do
    begin
      apb(1'b0, afbi_pkg::REG_STATUS, 32'h0000_0000);
      n++;
    end while (rd[afbi_pkg::ST_RDY_BIT] !== 1'b1 && n < 400);
    if (n >= 400)
      hang();
    if (c == afbi_pkg::OP_READ)
      apb(1'b0, afbi_pkg::REG_RDATA, 32'h0000_0000);
  endtask

  task automatic rdchk(input logic [23:0] x);
    op(afbi_pkg::OP_READ, x, 16'h0000);
    chk(rd, {16'h0000, fw(x)});
  endtask

  task automatic eight(input logic [31:0] cfg, input logic e);
    apb(1'b1, afbi_pkg::REG_CFG, cfg);
    op(afbi_pkg::OP_PAGECFG, 24'h00_0000, 16'h0000);
    chk({31'h0000_0000, i_afbi_flash_model.eight_q}, {31'h0000_0000, e});
  endtask

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    hang();
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    err_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, afbi_pkg::REG_CFG, 32'h0000_0000);
    chk(rd, afbi_pkg::CFG_RESET);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // Byte lane picked by the lowest address bit
    for (int i = 0; i < 2; i++)
    begin
      op(afbi_pkg::OP_READ, 24'h00_1232 + 24'(i), 16'h0000);
      w = fw(24'h00_1232);
      chk({24'h00_0000, rd[7:0]}, {24'h00_0000, i == 1 ? w[15:8] : w[7:0]});
    end
    apb(1'b1, afbi_pkg::REG_CFG, 32'h0000_0001);
    rdchk(24'h00_1236);
    rdchk(24'h00_1230);
    rdchk(24'h00_1236);
    rdchk(24'h00_1238);
    op(afbi_pkg::OP_WRITE, 24'h00_0000, 16'h0090);
    op(afbi_pkg::OP_READ, 24'h00_1238, 16'h0000);
    chk(rd, 32'h0000_0080);
    op(afbi_pkg::OP_WRITE, 24'h00_0000, afbi_pkg::CMD_READ_ARRAY);
    rdchk(24'h00_1238);
    op(afbi_pkg::OP_WRITE, 24'h00_0100, 16'h0040);
    op(afbi_pkg::OP_READ, 24'h00_0100, 16'h0000);
    chk(rd, 32'h0000_0000);
    op(afbi_pkg::OP_RESET, 24'h00_0000, 16'h0000);
    rdchk(24'h00_0100);
    eight(32'h0000_0005, 1'b1);
    apb(1'b0, afbi_pkg::REG_STATUS, 32'h0000_0000);
    chk({31'h0000_0000, rd[afbi_pkg::ST_EIGHT_BIT]}, 32'h0000_0001);
    rdchk(24'h00_123E);
    eight(32'h0000_0001, 1'b0);
    eight(32'h0000_0005, 1'b1);
    op(afbi_pkg::OP_RESET, 24'h00_0000, 16'h0000);
    chk({31'h0000_0000, i_afbi_flash_model.eight_q}, 32'h0000_0000);
    apb(1'b0, afbi_pkg::REG_STATUS, 32'h0000_0000);
    chk({31'h0000_0000, rd[afbi_pkg::ST_EIGHT_BIT]}, 32'h0000_0000);
    conclude();
  end
endmodule

// *** include/afbi_pkg.sv ***
/*
  Package for the asynchronous flash bus host controller: APB register map,
  command codes, pin timing counts and the pin carrier structs.
  Assumes a 20 MHz system clock and a flash device on plain asynchronous pins.
*/
// Contract
// - Hold reset low at least 25 us if device is busy working.
// - Idle device allows reset low pulse down to 100 ns.
// - Outputs valid only after recovery from later of busy or reset rise.
// - Read: select chip, output enable low, write strobe and reset high.
// - Never assert output enable and write strobe together; read wins.
// - Issue Read Array before page reads after any other operation; the host never issues it itself.
// - Configure: command write then confirm, value on address 15:0.
// - Eight-word mode needs Clear Status after page length configure.
package afbi_pkg;
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_ADDR       = 8'h04;
  localparam logic [7:0]  REG_WDATA      = 8'h08;
  localparam logic [7:0]  REG_RDATA      = 8'h0C;
  localparam logic [7:0]  REG_STATUS     = 8'h10;
  localparam logic [7:0]  REG_CFG        = 8'h14;
  // CTRL write: bits 2:0 start an operation
  localparam int          CTRL_OP_LSB    = 0;
  localparam logic [2:0]  OP_NONE        = 3'h0;
  localparam logic [2:0]  OP_READ        = 3'h1;
  localparam logic [2:0]  OP_WRITE       = 3'h2;
  localparam logic [2:0]  OP_RESET       = 3'h3;
  localparam logic [2:0]  OP_PAGECFG     = 3'h4;
  // CFG fields
  localparam int          CFG_BYTE_BIT   = 0;
  localparam int          CFG_BUSY_BIT   = 1;
  localparam int          CFG_EIGHT_BIT  = 2;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
  // Status fields
  localparam int          ST_BUSY_BIT    = 0;
  localparam int          ST_RDY_BIT     = 1;
  localparam int          ST_EIGHT_BIT   = 2;
  // Device command codes
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
  localparam logic [15:0] CMD_PAGE_CFG   = 16'h0060;
  localparam logic [15:0] CMD_PAGE_CONF  = 16'h0004;
  localparam logic [15:0] CMD_CLR_STATUS = 16'h0050;
  localparam int          PAGE_EIGHT_BIT = 13;
  // Timing in ns and derived cycles at 50 ns
  localparam int          CLK_NS         = 50;
  localparam int          RST_BUSY_NS    = 25000;
  localparam int          RST_IDLE_NS    = 100;
  localparam int          RST_RECOV_NS   = 210;
  localparam int          ACCESS_NS      = 95;
  localparam int          WR_PULSE_NS    = 60;
  localparam int          WR_HIGH_NS     = 35;
  localparam int          RST_BUSY_CYC   = (RST_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RST_IDLE_CYC   = (RST_IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RST_RECOV_CYC  = (RST_RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int          ACCESS_CYC     = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int          WR_PULSE_CYC   = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          WR_HIGH_CYC    = (WR_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W          = 10;

  typedef struct packed {
    logic        powerdown_reset_n;
    logic        chip_select_0;
    logic        chip_select_1;
    logic        chip_select_2;
    logic        oe_n;
    logic        we_n;
    logic        byte_n;
    logic [23:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe_n;
  } afbi_pins_t;

  typedef struct packed {
    logic [15:0] dq_in;
    logic        busy_indicator;
  } afbi_pins_in_t;
endpackage
